// file: logic/flic_pkg.sv
// shared constants for the four level interrupt controller
package flic_pkg;
    localparam int NUM_SRC = 13;
    localparam int PCYC_CLKS = 6;
    // apb byte offsets; the enable-low offset is the documented special-function address
    localparam logic [7:0] ADDR_IEN_LOW = 8'hA8;
    localparam logic [7:0] ADDR_IEN_HIGH = 8'hB1;
    localparam logic [7:0] ADDR_PRIO_LSB_A = 8'hB8;
    localparam logic [7:0] ADDR_PRIO_LSB_B = 8'hB2;
    localparam logic [7:0] ADDR_PRIO_MSB_A = 8'hB7;
    localparam logic [7:0] ADDR_PRIO_MSB_B = 8'hB3;
    localparam logic [7:0] ADDR_TCTL = 8'h88;
    localparam logic [7:0] ADDR_STATUS = 8'hC0;
    localparam logic [7:0] ADDR_MASK = 8'hC4;
    localparam logic [7:0] ADDR_INSVC = 8'hC8;
    // bit positions inside the first enable register
    localparam int GATE_BIT = 7;
    localparam int RSV_BIT = 5;
    localparam logic [7:0] IEN_LOW_MASK = 8'hDF;
    localparam logic [7:0] BANK_B_MASK = 8'h5D;
    localparam logic [7:0] BANK_A_MASK = 8'h5F;
    // timer control bits: pin request flags and trigger selects
    localparam int TC_PIN1_FLAG = 3;
    localparam int TC_PIN1_SEL = 2;
    localparam int TC_PIN0_FLAG = 1;
    localparam int TC_PIN0_SEL = 0;
    // source indices in polling order, 0 is polled first
    localparam int SRC_PIN0 = 0;
    localparam int SRC_TMR0 = 1;
    localparam int SRC_PIN1 = 2;
    localparam int SRC_TMR1 = 3;
    // vector table in polling order
    localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
        16'h002B, 16'h003B, 16'h004B, 16'h0053, 16'h005B, 16'h0063, 16'h006B, 16'h0073};
    localparam logic [3:0] EVT_VECTOR = 4'h1;
    localparam logic [3:0] EVT_WAKE = 4'h2;
endpackage : flic_pkg

// file: logic/flic_pin_sampler.sv
// external pin synchroniser, peripheral-cycle sampler and trigger detector
`timescale 1ns/1ns
module flic_pin_sampler
    import flic_pkg::*;
#(
    parameter int W = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic samp_en,
    input wire logic [W-1:0] pin_n,
    output logic [W-1:0] level_low,
    output logic [W-1:0] fall_evt,
    output logic [W-1:0] async_low
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] samp_ff;
    logic [W-1:0] prev_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= '1;
            sync_ff <= '1;
        end else begin
            meta_ff <= pin_n;
            sync_ff <= meta_ff;
        end
    end

    // one sample per peripheral cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            samp_ff <= '1;
            prev_ff <= '1;
        end else if (samp_en) begin
            samp_ff <= sync_ff;
            prev_ff <= samp_ff;
        end
    end

    assign level_low = ~samp_ff;
    assign fall_evt = prev_ff & ~samp_ff;
    assign async_low = ~sync_ff;
endmodule : flic_pin_sampler

// file: logic/flic_arbiter.sv
// priority arbiter: highest level wins, ties by polling order
`timescale 1ns/1ns
module flic_arbiter
    import flic_pkg::*;
#(
    parameter int N = NUM_SRC
) (
    input wire logic [N-1:0] req,
    input wire logic [N-1:0] prio_msb,
    input wire logic [N-1:0] prio_lsb,
    output logic found,
    output logic [3:0] win_idx,
    output logic [1:0] win_lvl
);
    always_comb begin
        found = 1'b0;
        win_idx = 4'h0;
        win_lvl = 2'h0;
        for (int i = 0; i < N; i++) begin
            if (req[i] && (!found || {prio_msb[i], prio_lsb[i]} > win_lvl)) begin
                found = 1'b1;
                win_idx = 4'(i);
                win_lvl = {prio_msb[i], prio_lsb[i]};
            end
        end
    end
endmodule : flic_arbiter

// file: logic/flic_top.sv
// four level interrupt controller with apb registers and cpu vector handshake
// Contract
// - each source has a two bit level, 00 lowest, 11 highest; sources 10 and 12 have no enable or level bits here and never vector
// - running handler is pre-empted only by a strictly higher level
// - among pending levels the highest is vectored first
// - equal levels resolved by fixed polling order, pin 0 first
// - each source vectors to its fixed code address
// - hardware clears timer and edge pin flags on vectoring; software the rest
// - trigger select 0 means low level, 1 means falling edge
// - a pin event sets its request flag in timer control
// - edge pin flag clears automatically on vectoring
// - low level on either pin wakes from power down
// - pins and keypad inputs sampled once per six clock peripheral cycle
// - global gate at bit 7 blocks all interrupts when clear
// - per source enables at bits 6,4,3,2,1,0 of first enable register
// - bit 5 of first enable register reads zero, never written one
// - vector taken after instruction, return restores and clears in-progress level
`timescale 1ns/1ns
module flic_top
    import flic_pkg::*;
#(
    parameter int PCYC = PCYC_CLKS
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [7:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic EXT_PIN_IRQ_ZERO_N,
    input wire logic EXT_PIN_IRQ_ONE_N,
    input wire logic [3:0] KEYPAD_IRQ_INPUTS_N,
    output logic [3:0] KEYPAD_LEVEL_LOW,
    input wire logic TIMER_ZERO_OVF,
    input wire logic TIMER_ONE_OVF,
    input wire logic [NUM_SRC-1:0] PERIPH_REQ,
    input wire logic POWER_DOWN,
    output logic WAKE_UP,
    input wire logic CPU_INSTR_BOUNDARY,
    input wire logic CPU_RETURN_FROM_HANDLER,
    output logic CPU_VECTOR_REQ,
    output logic [15:0] CPU_VECTOR_ADDR,
    output logic IRQ
);
    logic [7:0] ien_low_ff;
    logic [7:0] ien_high_ff;
    logic [7:0] lsb_a_ff;
    logic [7:0] lsb_b_ff;
    logic [7:0] msb_a_ff;
    logic [7:0] msb_b_ff;
    logic [3:0] tctl_ff;
    logic [NUM_SRC-1:0] flags;
    logic pin0_flag_ff;
    logic pin1_flag_ff;
    logic tmr0_flag_ff;
    logic tmr1_flag_ff;
    logic [NUM_SRC-1:SRC_TMR1+1] per_flag_ff;
    logic tctl_wr;
    logic [3:0] active_ff;
    logic [3:0] evt_ff;
    logic [3:0] evt_mask_ff;
    logic [2:0] pcnt_ff;
    logic samp_en;
    logic [5:0] low_lvl;
    logic [5:0] fall;
    logic [5:0] async_low;
    logic [NUM_SRC-1:0] enab;
    logic [NUM_SRC-1:0] req;
    logic [NUM_SRC-1:0] pmsb;
    logic [NUM_SRC-1:0] plsb;
    logic found;
    logic [3:0] win_idx;
    logic [1:0] win_lvl;
    logic [2:0] act_lvl;
    logic take;
    logic wr;
    logic rd_ok;
    logic [7:0] rd_val;
    logic [NUM_SRC-1:0] vec_clr;
    logic [3:0] nxt_active;

    // map two register banks onto polling order: a-bank bits 0..4,6 and b-bank bits 0,2,3,4,6
    function automatic logic [NUM_SRC-1:0] to_src(input logic [7:0] a, input logic [7:0] b);
        to_src = {1'b0, b[6], 1'b0, b[4], b[3], b[2], b[0], a[6], a[4], a[3], a[2], a[1], a[0]};
    endfunction : to_src

    // pin event in the selected trigger mode; an edge counts once, at a sample tick
    function automatic logic pin_event(input logic edge_mode, input logic fall_seen, input logic low_seen,
        input logic tick);
        pin_event = edge_mode ? (fall_seen && tick) : low_seen;
    endfunction : pin_event

    // write strobe for one register offset
    function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] offs);
        wr_hit = w && (a == offs);
    endfunction : wr_hit

    // peripheral cycle divider
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pcnt_ff <= 3'h0;
        end else if (pcnt_ff == 3'(PCYC - 1)) begin
            pcnt_ff <= 3'h0;
        end else begin
            pcnt_ff <= pcnt_ff + 3'h1;
        end
    end
    assign samp_en = (pcnt_ff == 3'(PCYC - 1));

    flic_pin_sampler #(.W(6)) u_pins (
        .clk(MCLK),
        .rst(RST),
        .samp_en(samp_en),
        .pin_n({KEYPAD_IRQ_INPUTS_N, EXT_PIN_IRQ_ONE_N, EXT_PIN_IRQ_ZERO_N}),
        .level_low(low_lvl),
        .fall_evt(fall),
        .async_low(async_low)
    );
    assign KEYPAD_LEVEL_LOW = low_lvl[5:2];
    assign WAKE_UP = POWER_DOWN && (async_low[0] || async_low[1]);

    assign wr = PSEL && PENABLE && PWRITE;
    assign PREADY = 1'b1;

    // arbitration set
    assign enab = to_src(ien_low_ff, ien_high_ff) & {NUM_SRC{ien_low_ff[GATE_BIT]}};
    assign req = flags & enab;
    assign pmsb = to_src(msb_a_ff, msb_b_ff);
    assign plsb = to_src(lsb_a_ff, lsb_b_ff);

    flic_arbiter #(.N(NUM_SRC)) u_arb (
        .req(req),
        .prio_msb(pmsb),
        .prio_lsb(plsb),
        .found(found),
        .win_idx(win_idx),
        .win_lvl(win_lvl)
    );

    // highest level in service, 4 means none
    always_comb begin
        act_lvl = 3'h4;
        for (int l = 3; l >= 0; l--) begin
            if (active_ff[l] && act_lvl == 3'h4) begin
                act_lvl = 3'(l);
            end
        end
    end
    assign take = found && CPU_INSTR_BOUNDARY && (act_lvl == 3'h4 || {1'b0, win_lvl} > act_lvl);

    // in-progress levels: set on vectoring, top one cleared on return
    always_comb begin
        nxt_active = active_ff;
        if (CPU_RETURN_FROM_HANDLER && act_lvl != 3'h4) begin
            nxt_active[act_lvl[1:0]] = 1'b0;
        end
        if (take) begin
            nxt_active[win_lvl] = 1'b1;
        end
    end
    always_ff @(posedge MCLK) begin
        if (RST) begin
            active_ff <= 4'h0;
        end else begin
            active_ff <= nxt_active;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            CPU_VECTOR_REQ <= 1'b0;
            CPU_VECTOR_ADDR <= 16'h0000;
        end else begin
            CPU_VECTOR_REQ <= take;
            if (take) begin
                CPU_VECTOR_ADDR <= VEC_TABLE[win_idx];
            end
        end
    end

    // hardware clears on vectoring: timers always, pins only in edge mode
    always_comb begin
        vec_clr = '0;
        if (take) begin
            if (win_idx == 4'(SRC_TMR0) || win_idx == 4'(SRC_TMR1)) begin
                vec_clr[win_idx] = 1'b1;
            end
            if (win_idx == 4'(SRC_PIN0) && tctl_ff[TC_PIN0_SEL]) begin
                vec_clr[win_idx] = 1'b1;
            end
            if (win_idx == 4'(SRC_PIN1) && tctl_ff[TC_PIN1_SEL]) begin
                vec_clr[win_idx] = 1'b1;
            end
        end
    end

    // pin request flags latch regardless of enables; a new event wins over any clear
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pin0_flag_ff <= 1'b0;
        end else begin
            pin0_flag_ff <= pin_event(tctl_ff[TC_PIN0_SEL], fall[0], low_lvl[0], samp_en)
                || (pin0_flag_ff && !vec_clr[SRC_PIN0] && !(tctl_wr && !PWDATA[TC_PIN0_FLAG]));
        end
    end
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pin1_flag_ff <= 1'b0;
        end else begin
            pin1_flag_ff <= pin_event(tctl_ff[TC_PIN1_SEL], fall[1], low_lvl[1], samp_en)
                || (pin1_flag_ff && !vec_clr[SRC_PIN1] && !(tctl_wr && !PWDATA[TC_PIN1_FLAG]));
        end
    end

    // timer flags: set by overflow, cleared only on vectoring
    always_ff @(posedge MCLK) begin
        if (RST) begin
            tmr0_flag_ff <= 1'b0;
        end else begin
            tmr0_flag_ff <= TIMER_ZERO_OVF || PERIPH_REQ[SRC_TMR0] || (tmr0_flag_ff && !vec_clr[SRC_TMR0]);
        end
    end
    always_ff @(posedge MCLK) begin
        if (RST) begin
            tmr1_flag_ff <= 1'b0;
        end else begin
            tmr1_flag_ff <= TIMER_ONE_OVF || PERIPH_REQ[SRC_TMR1] || (tmr1_flag_ff && !vec_clr[SRC_TMR1]);
        end
    end

    // peripheral flags mirror their sources, which software clears at the peripheral
    always_ff @(posedge MCLK) begin
        if (RST) begin
            per_flag_ff <= '0;
        end else begin
            per_flag_ff <= PERIPH_REQ[NUM_SRC-1:SRC_TMR1+1];
        end
    end
    assign flags = {per_flag_ff, tmr1_flag_ff, pin1_flag_ff, tmr0_flag_ff, pin0_flag_ff};
    assign tctl_wr = wr_hit(wr, PADDR, ADDR_TCTL);

    // configuration registers, one per offset
    always_ff @(posedge MCLK) begin
        if (RST) begin
            ien_low_ff <= 8'h00;
        end else if (wr_hit(wr, PADDR, ADDR_IEN_LOW)) begin
            ien_low_ff <= PWDATA[7:0] & IEN_LOW_MASK;
        end
    end
    always_ff @(posedge MCLK) begin
        if (RST) begin
            ien_high_ff <= 8'h00;
        end else if (wr_hit(wr, PADDR, ADDR_IEN_HIGH)) begin
            ien_high_ff <= PWDATA[7:0] & BANK_B_MASK;
        end
    end
    always_ff @(posedge MCLK) begin
        if (RST) begin
            lsb_a_ff <= 8'h00;
        end else if (wr_hit(wr, PADDR, ADDR_PRIO_LSB_A)) begin
            lsb_a_ff <= PWDATA[7:0] & BANK_A_MASK;
        end
    end
    always_ff @(posedge MCLK) begin
        if (RST) begin
            lsb_b_ff <= 8'h00;
        end else if (wr_hit(wr, PADDR, ADDR_PRIO_LSB_B)) begin
            lsb_b_ff <= PWDATA[7:0] & BANK_B_MASK;
        end
    end
    always_ff @(posedge MCLK) begin
        if (RST) begin
            msb_a_ff <= 8'h00;
        end else if (wr_hit(wr, PADDR, ADDR_PRIO_MSB_A)) begin
            msb_a_ff <= PWDATA[7:0] & BANK_A_MASK;
        end
    end
    always_ff @(posedge MCLK) begin
        if (RST) begin
            msb_b_ff <= 8'h00;
        end else if (wr_hit(wr, PADDR, ADDR_PRIO_MSB_B)) begin
            msb_b_ff <= PWDATA[7:0] & BANK_B_MASK;
        end
    end
    always_ff @(posedge MCLK) begin
        if (RST) begin
            tctl_ff <= 4'h0;
        end else if (tctl_wr) begin
            tctl_ff <= {1'b0, PWDATA[TC_PIN1_SEL], 1'b0, PWDATA[TC_PIN0_SEL]};
        end
    end
    always_ff @(posedge MCLK) begin
        if (RST) begin
            evt_mask_ff <= 4'h0;
        end else if (wr_hit(wr, PADDR, ADDR_MASK)) begin
            evt_mask_ff <= PWDATA[3:0];
        end
    end

    // sticky event status, write one to clear, set wins
    always_ff @(posedge MCLK) begin
        if (RST) begin
            evt_ff <= 4'h0;
        end else begin
            evt_ff <= (evt_ff & ~((wr && PADDR == ADDR_STATUS) ? PWDATA[3:0] : 4'h0))
                | (take ? EVT_VECTOR : 4'h0) | (WAKE_UP ? EVT_WAKE : 4'h0);
        end
    end
    assign IRQ = |(evt_ff & evt_mask_ff);

    // read mux
    always_comb begin
        rd_ok = 1'b1;
        rd_val = 8'h00;
        if (PADDR == ADDR_IEN_LOW) begin
            rd_val = ien_low_ff;
        end else if (PADDR == ADDR_IEN_HIGH) begin
            rd_val = ien_high_ff;
        end else if (PADDR == ADDR_PRIO_LSB_A) begin
            rd_val = lsb_a_ff;
        end else if (PADDR == ADDR_PRIO_LSB_B) begin
            rd_val = lsb_b_ff;
        end else if (PADDR == ADDR_PRIO_MSB_A) begin
            rd_val = msb_a_ff;
        end else if (PADDR == ADDR_PRIO_MSB_B) begin
            rd_val = msb_b_ff;
        end else if (PADDR == ADDR_TCTL) begin
            rd_val = {4'h0, pin1_flag_ff, tctl_ff[2], pin0_flag_ff, tctl_ff[0]};
        end else if (PADDR == ADDR_STATUS) begin
            rd_val = {4'h0, evt_ff};
        end else if (PADDR == ADDR_MASK) begin
            rd_val = {4'h0, evt_mask_ff};
        end else if (PADDR == ADDR_INSVC) begin
            rd_val = {4'h0, active_ff};
        end else begin
            rd_ok = 1'b0;
        end
    end
    assign PSLVERR = PSEL && PENABLE && !rd_ok;
    always_ff @(posedge MCLK) begin
        if (RST) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= {24'h000000, rd_val};
        end
    end
endmodule : flic_top

// file: sim/flic_checker.sv
// port assertions for the four level interrupt controller
`timescale 1ns/1ns
module flic_checker
    import flic_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [7:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PRDATA,
    input wire logic EXT_PIN_IRQ_ZERO_N,
    input wire logic [3:0] KEYPAD_IRQ_INPUTS_N,
    input wire logic [3:0] KEYPAD_LEVEL_LOW,
    input wire logic POWER_DOWN,
    input wire logic WAKE_UP,
    input wire logic CPU_INSTR_BOUNDARY,
    input wire logic CPU_VECTOR_REQ,
    input wire logic [15:0] CPU_VECTOR_ADDR
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    a_vec_one_cycle: assert property (CPU_VECTOR_REQ |=> !CPU_VECTOR_REQ)
        else $error("vector request too long");
    a_vec_on_boundary: assert property (CPU_VECTOR_REQ |-> $past(CPU_INSTR_BOUNDARY))
        else $error("vector without boundary");
    a_vec_addr_form: assert property (CPU_VECTOR_REQ |-> CPU_VECTOR_ADDR[2:0] == 3'h3
        && CPU_VECTOR_ADDR <= 16'h0073)
        else $error("bad vector address");
    a_vec_addr_hold: assert property (!CPU_VECTOR_REQ |-> $stable(CPU_VECTOR_ADDR))
        else $error("vector address moved");
    a_wake_needs_pd: assert property (WAKE_UP |-> POWER_DOWN)
        else $error("wake outside power down");
    a_wake_on_low: assert property ((POWER_DOWN && !EXT_PIN_IRQ_ZERO_N) [*3] |-> WAKE_UP)
        else $error("no wake on low pin");
    a_ien_rsv_zero: assert property (PSEL && PENABLE && !PWRITE && PADDR == ADDR_IEN_LOW |-> !PRDATA[RSV_BIT])
        else $error("reserved enable bit reads one");
    a_keypad_idle: assert property (KEYPAD_IRQ_INPUTS_N[0] [*8] ##1 KEYPAD_IRQ_INPUTS_N[0] [*3]
        |-> !KEYPAD_LEVEL_LOW[0])
        else $error("keypad low while pin high");
endmodule : flic_checker

bind flic_top flic_checker chk_u (.MCLK, .RST, .PADDR, .PSEL, .PENABLE, .PWRITE, .PRDATA, .EXT_PIN_IRQ_ZERO_N,
    .KEYPAD_IRQ_INPUTS_N, .KEYPAD_LEVEL_LOW, .POWER_DOWN, .WAKE_UP, .CPU_INSTR_BOUNDARY, .CPU_VECTOR_REQ,
    .CPU_VECTOR_ADDR);

// file: sim/flic_cpu_model.sv
// cpu execution unit stand-in: instruction boundary and return pulses
`timescale 1ns/1ns
module flic_cpu_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic allow,
    input wire logic ret_cmd,
    output logic boundary_ff,
    output logic ret_ff
);
    always_ff @(posedge clk) begin
        if (rst) begin
            boundary_ff <= 1'b0;
            ret_ff <= 1'b0;
        end else begin
            boundary_ff <= allow;
            ret_ff <= ret_cmd;
        end
    end
endmodule : flic_cpu_model

// file: sim/tb_four_level_interrupt_controller.sv
// self-checking bench for the four level interrupt controller
`timescale 1ns/1ns
module tb_four_level_interrupt_controller
    import flic_pkg::*;
;
    localparam int IX [7] = '{4, 5, 6, 7, 8, 9, 11};
    localparam logic [7:0] EN [7] = '{8'h90, 8'hC0, 8'h01, 8'h04, 8'h08, 8'h10, 8'h40};
    localparam logic [15:0] VV [7] = '{16'h0023, 16'h002B, 16'h003B, 16'h004B, 16'h0053, 16'h005B, 16'h006B};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic pin0_n = 1'b1;
    logic pin1_n = 1'b1;
    logic [3:0] kp_n = 4'hF;
    logic tmr0 = 1'b0;
    logic tmr1 = 1'b0;
    logic [NUM_SRC-1:0] preq = '0;
    logic pdown = 1'b0;
    logic allow = 1'b0;
    logic ret_cmd = 1'b0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [15:0] vaddr;
    logic [3:0] kp_low;
    logic pready, pslverr, err, wake, bnd, retp, vreq, irq;
    int n_mismatch = 0;
    int n_tests = 0;

    initial begin
        forever #4 mclk = ~mclk;
    end

    flic_top dut_u (.MCLK(mclk), .RST(rst), .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EXT_PIN_IRQ_ZERO_N(pin0_n),
        .EXT_PIN_IRQ_ONE_N(pin1_n), .KEYPAD_IRQ_INPUTS_N(kp_n), .KEYPAD_LEVEL_LOW(kp_low), .TIMER_ZERO_OVF(tmr0),
        .TIMER_ONE_OVF(tmr1), .PERIPH_REQ(preq), .POWER_DOWN(pdown), .WAKE_UP(wake), .CPU_INSTR_BOUNDARY(bnd),
        .CPU_RETURN_FROM_HANDLER(retp), .CPU_VECTOR_REQ(vreq), .CPU_VECTOR_ADDR(vaddr), .IRQ(irq));
    flic_cpu_model cpu_u (.clk(mclk), .rst(rst), .allow(allow), .ret_cmd(ret_cmd), .boundary_ff(bnd), .ret_ff(retp));

    task close_out;
        if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wait_vec(input logic [15:0] exp);
        int i;
        @(posedge mclk);
        allow <= 1'b1;
        i = 0;
        do begin
            @(posedge mclk);
            #1;
            i++;
        end while (vreq !== 1'b1 && i < 60);
        chk({15'h0, vreq, vaddr}, {15'h0, 1'b1, exp});
        @(posedge mclk);
        allow <= 1'b0;
    endtask : wait_vec

    task no_vec(input int n);
        @(posedge mclk);
        allow <= 1'b1;
        repeat (n) begin
            @(posedge mclk);
            #1;
            chk({31'h0, vreq}, 32'h0);
        end
        @(posedge mclk);
        allow <= 1'b0;
    endtask : no_vec

    task ret;
        @(posedge mclk);
        ret_cmd <= 1'b1;
        @(posedge mclk);
        ret_cmd <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : ret

    task tmr(input logic a, input logic b);
        @(posedge mclk);
        tmr0 <= a;
        tmr1 <= b;
        @(posedge mclk);
        tmr0 <= 1'b0;
        tmr1 <= 1'b0;
    endtask : tmr

    task t_regs;
        apb(1'b0, ADDR_IEN_LOW, 8'h00);
        chk(rd, 32'h0);
        apb(1'b1, ADDR_IEN_LOW, 8'hFF);
        apb(1'b0, ADDR_IEN_LOW, 8'h00);
        chk(rd, 32'hDF);
        apb(1'b0, 8'h04, 8'h00);
        chk({rd[30:0], err}, 32'h1);
    endtask : t_regs

    task t_poll;
        apb(1'b1, ADDR_IEN_LOW, 8'h8F);
        tmr(1'b1, 1'b1);
        wait_vec(16'h000B);
        no_vec(10);
        ret();
        wait_vec(16'h001B);
        ret();
        no_vec(10);
    endtask : t_poll

    task t_level;
        apb(1'b1, ADDR_PRIO_MSB_A, 8'h08);
        apb(1'b1, ADDR_PRIO_LSB_A, 8'h08);
        tmr(1'b1, 1'b1);
        wait_vec(16'h001B);
        no_vec(8);
        ret();
        wait_vec(16'h000B);
        tmr(1'b0, 1'b1);
        wait_vec(16'h001B);
        apb(1'b0, ADDR_INSVC, 8'h00);
        chk(rd, 32'h9);
        ret();
        ret();
        apb(1'b1, ADDR_PRIO_LSB_A, 8'h02);
        tmr(1'b1, 1'b1);
        wait_vec(16'h001B);
        ret();
        wait_vec(16'h000B);
        ret();
        apb(1'b1, ADDR_PRIO_MSB_A, 8'h00);
        apb(1'b1, ADDR_PRIO_LSB_A, 8'h00);
    endtask : t_level

    task t_gate;
        apb(1'b1, ADDR_IEN_LOW, 8'h0F);
        tmr(1'b1, 1'b0);
        no_vec(10);
        apb(1'b1, ADDR_IEN_LOW, 8'h8F);
        wait_vec(16'h000B);
        ret();
    endtask : t_gate

    task t_pins;
        apb(1'b1, ADDR_TCTL, 8'h01);
        @(posedge mclk);
        pdown <= 1'b1;
        pin0_n <= 1'b0;
        kp_n <= 4'hA;
        repeat (16) @(posedge mclk);
        chk({27'h0, kp_low, wake}, 32'hB);
        pdown <= 1'b0;
        pin0_n <= 1'b1;
        apb(1'b0, ADDR_TCTL, 8'h00);
        chk(rd & 32'h2, 32'h2);
        wait_vec(16'h0003);
        apb(1'b0, ADDR_TCTL, 8'h00);
        chk(rd & 32'h2, 32'h0);
        ret();
        no_vec(12);
        apb(1'b1, ADDR_TCTL, 8'h00);
        @(posedge mclk);
        pin1_n <= 1'b0;
        repeat (12) @(posedge mclk);
        wait_vec(16'h0013);
        pin1_n <= 1'b1;
        repeat (12) @(posedge mclk);
        apb(1'b1, ADDR_TCTL, 8'h00);
        ret();
        apb(1'b1, ADDR_TCTL, 8'h04);
        @(posedge mclk);
        pin1_n <= 1'b0;
        repeat (16) @(posedge mclk);
        pin1_n <= 1'b1;
        wait_vec(16'h0013);
        apb(1'b0, ADDR_TCTL, 8'h00);
        chk(rd & 32'h8, 32'h0);
        ret();
        no_vec(12);
    endtask : t_pins

    task t_periph;
        for (int k = 0; k < 7; k++) begin
            apb(1'b1, k < 2 ? ADDR_IEN_LOW : ADDR_IEN_HIGH, EN[k]);
            @(posedge mclk);
            preq[IX[k]] <= 1'b1;
            wait_vec(VV[k]);
            preq[IX[k]] <= 1'b0;
            ret();
        end
        no_vec(10);
    endtask : t_periph

    task t_irq;
        apb(1'b1, ADDR_MASK, 8'h01);
        #1;
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, ADDR_MASK, 8'h00);
        #1;
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_MASK, 8'h01);
        apb(1'b1, ADDR_STATUS, 8'h03);
        #1;
        chk({31'h0, irq}, 32'h0);
    endtask : t_irq

    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_poll();
        t_level();
        t_gate();
        t_pins();
        t_periph();
        t_irq();
        close_out();
    end

    initial begin
        repeat (30000) @(posedge mclk);
        n_mismatch++;
        close_out();
    end
endmodule : tb_four_level_interrupt_controller
